// ---- design/afe_power_pkg.sv ----
// Purpose: shared constants and carriers for the converter reset and power block
// Assumes: 32-bit AXI4-Lite register access, 10 MHz aclk
// Notes: six channels, one register word each for setup and status
package afe_power_pkg;
  localparam int NUM_CH = 6;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] SETUP_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  // channel_setup_register fields
  localparam int SHUTDOWN_LSB = 0;
  localparam int SOFT_RESET_LSB = 8;
  localparam int EXT_REF_BIT = 16;
  localparam int EXT_CLK_BIT = 17;
  // status register fields
  localparam int ST_ACTIVE_LSB = 0;
  localparam int ST_SETTLING_LSB = 8;
  localparam int ST_CORE_CLK_BIT = 16;
  localparam int ST_INPUT_CLK_BIT = 17;
  localparam int ST_FULL_DOWN_BIT = 18;
  localparam int ST_MONITOR_BIT = 19;
  // reset values
  localparam logic [NUM_CH-1:0] SHUTDOWN_RESET = 6'h00;
  localparam logic [NUM_CH-1:0] SOFT_RESET_RESET = 6'h00;
  localparam logic EXT_REF_RESET = 1'h0;
  localparam logic EXT_CLK_RESET = 1'h0;
  localparam logic [NUM_CH-1:0] ALL_DOWN = 6'h3F;
  localparam logic [3:0] QUANT_RESET_PATTERN = 4'h3;
  // filter settling time after a channel resumes
  localparam int SETTLE_TIME_US = 100;
  localparam int CLOCK_MHZ = 10;
  localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLOCK_MHZ;
  localparam int SETTLE_W = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic [NUM_CH-1:0] bias_en;
    logic [NUM_CH-1:0] chan_clk_en;
    logic [NUM_CH-1:0] quant_preset;
    logic [NUM_CH-1:0] filter_clear;
    logic core_clk_en;
    logic input_clk_en;
    logic vref_en;
    logic monitor_en;
    logic serial_reset;
  } power_ctl_t;
endpackage

// ---- design/afe_reset_and_power_modes.sv ----
// Purpose: reset and power-mode control for a six-channel delta-sigma front end
// Assumes: modulator/filter data and conversion strobes arrive on aclk
// Notes: reset pin and power-on detector are asynchronous and resynchronised
`timescale 1ns/1ps
module afe_reset_and_power_modes
  import afe_power_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic por_detect,
  input wire axi_req_t axi_req,
  output axi_rsp_t axi_rsp,
  input wire logic [NUM_CH-1:0][DATA_W-1:0] conv_data,
  input wire logic [NUM_CH-1:0] conv_strobe,
  output logic [NUM_CH-1:0][DATA_W-1:0] data_out,
  output logic [NUM_CH-1:0] data_ready,
  output power_ctl_t power_ctl
);

  typedef struct packed {
    logic [2:0] pin_sync;
    logic [2:0] por_sync;
    logic pin_level;
    logic por_level;
    logic [NUM_CH-1:0] shutdown;
    logic [NUM_CH-1:0] soft_reset;
    logic ext_ref;
    logic ext_clk;
    logic [NUM_CH-1:0][SETTLE_W-1:0] settle;
    logic [NUM_CH-1:0] wait_strobe;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axi_rsp_t rsp;
    logic [NUM_CH-1:0][DATA_W-1:0] dout;
    logic [NUM_CH-1:0] drdy;
    power_ctl_t ctl;
  } state_t;

  state_t cur;
  state_t next_cur;

  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYCLES);

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    s.pin_sync = 3'h7;
    s.pin_level = 1'h1;
    s.shutdown = SHUTDOWN_RESET;
    s.soft_reset = SOFT_RESET_RESET;
    s.ext_ref = EXT_REF_RESET;
    s.ext_clk = EXT_CLK_RESET;
    return s;
  endfunction

  always_comb
  begin
    logic hard;
    logic [NUM_CH-1:0] active;
    logic full_down;
    logic do_write;
    logic do_read;
    logic [31:0] setup_word;
    logic [31:0] status_word;
    logic [31:0] new_setup;
    logic [NUM_CH-1:0] settling;
    hard = 1'h0;
    active = '0;
    full_down = 1'h0;
    do_write = 1'h0;
    do_read = 1'h0;
    setup_word = '0;
    status_word = '0;
    new_setup = '0;
    settling = '0;
    next_cur = cur;

    // three-stage synchronisers; level moves only when stages two and three agree
    next_cur.pin_sync = {cur.pin_sync[1:0], reset_pin_n};
    next_cur.por_sync = {cur.por_sync[1:0], por_detect};
    if (cur.pin_sync[1] == cur.pin_sync[2])
    begin
      next_cur.pin_level = cur.pin_sync[2];
    end
    if (cur.por_sync[1] == cur.por_sync[2])
    begin
      next_cur.por_level = cur.por_sync[2];
    end
    hard = cur.por_level | ~cur.pin_level;

    active = ~cur.shutdown;
    full_down = (cur.shutdown == ALL_DOWN) & cur.ext_ref & cur.ext_clk;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // settling until the first strobe after the count runs out
      settling[i] = (cur.settle[i] != '0) | cur.wait_strobe[i];
    end

    setup_word[SHUTDOWN_LSB +: NUM_CH] = cur.shutdown;
    setup_word[SOFT_RESET_LSB +: NUM_CH] = cur.soft_reset;
    setup_word[EXT_REF_BIT] = cur.ext_ref;
    setup_word[EXT_CLK_BIT] = cur.ext_clk;
    status_word[ST_ACTIVE_LSB +: NUM_CH] = active;
    status_word[ST_SETTLING_LSB +: NUM_CH] = settling;
    status_word[ST_CORE_CLK_BIT] = cur.ctl.core_clk_en;
    status_word[ST_INPUT_CLK_BIT] = cur.ctl.input_clk_en;
    status_word[ST_FULL_DOWN_BIT] = full_down;
    status_word[ST_MONITOR_BIT] = cur.ctl.monitor_en;
    // status is read-only: a write to it is answered and dropped

    // write channel: address and data taken in either order, response after both
    if (axi_req.awvalid && cur.rsp.awready)
    begin
      next_cur.aw_got = 1'h1;
      next_cur.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && cur.rsp.wready)
    begin
      next_cur.w_got = 1'h1;
      next_cur.w_data = axi_req.wdata;
      next_cur.w_strb = axi_req.wstrb;
    end
    if (cur.rsp.bvalid && axi_req.bready)
    begin
      next_cur.rsp.bvalid = 1'h0;
    end
    do_write = next_cur.aw_got & next_cur.w_got & ~next_cur.rsp.bvalid;
    if (do_write)
    begin
      next_cur.aw_got = 1'h0;
      next_cur.w_got = 1'h0;
      next_cur.rsp.bvalid = 1'h1;
      next_cur.rsp.bresp = RESP_OKAY;
      if (next_cur.aw_addr == SETUP_OFFSET)
      begin
        new_setup = setup_word;
        for (int b = 0; b < 4; b++)
        begin
          if (next_cur.w_strb[b])
          begin
            new_setup[b*8 +: 8] = next_cur.w_data[b*8 +: 8];
          end
        end
        // only this write path and the resets change configuration; power modes never do
        next_cur.shutdown = new_setup[SHUTDOWN_LSB +: NUM_CH];
        next_cur.soft_reset = new_setup[SOFT_RESET_LSB +: NUM_CH];
        next_cur.ext_ref = new_setup[EXT_REF_BIT];
        next_cur.ext_clk = new_setup[EXT_CLK_BIT];
      end
      else if (next_cur.aw_addr != STATUS_OFFSET)
      begin
        next_cur.rsp.bresp = RESP_SLVERR;
      end
    end

    // read channel; stays open in full power-down so software can wake the part
    if (cur.rsp.rvalid && axi_req.rready)
    begin
      next_cur.rsp.rvalid = 1'h0;
    end
    // a read beside a write in one cycle sees the setup word from before the write
    do_read = axi_req.arvalid & cur.rsp.arready;
    if (do_read)
    begin
      next_cur.rsp.rvalid = 1'h1;
      next_cur.rsp.rresp = RESP_OKAY;
      if (axi_req.araddr == SETUP_OFFSET)
      begin
        next_cur.rsp.rdata = setup_word;
      end
      else if (axi_req.araddr == STATUS_OFFSET)
      begin
        next_cur.rsp.rdata = status_word;
      end
      else
      begin
        next_cur.rsp.rdata = '0;
        next_cur.rsp.rresp = RESP_SLVERR;
      end
    end
    next_cur.rsp.awready = ~next_cur.aw_got & ~next_cur.rsp.bvalid;
    next_cur.rsp.wready = ~next_cur.w_got & ~next_cur.rsp.bvalid;
    next_cur.rsp.arready = ~next_cur.rsp.rvalid;

    // per-channel settle tracking and output path
    next_cur.drdy = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // a write that powers the channel down also drops a strobe in the same cycle
      if (cur.shutdown[i] || next_cur.shutdown[i])
      begin
        // re-armed each cycle so the channel restarts settling on exit
        next_cur.settle[i] = SETTLE_LOAD;
        next_cur.wait_strobe[i] = 1'h1;
        next_cur.dout[i] = '0;
      end
      else if (cur.settle[i] != '0)
      begin
        next_cur.settle[i] = cur.settle[i] - SETTLE_W'(1);
        next_cur.dout[i] = '0;
      end
      else if (cur.soft_reset[i])
      begin
        next_cur.dout[i] = '0;
      end
      else if (conv_strobe[i])
      begin
        // strobes come from the shared running clock, so the first one after
        // settling keeps the channel's phase relation to the active channels
        next_cur.wait_strobe[i] = 1'h0;
        next_cur.dout[i] = conv_data[i];
        next_cur.drdy[i] = 1'h1;
      end
    end

    // power controls; shutdown outranks soft reset for biases and clocks
    next_cur.ctl.bias_en = ~next_cur.shutdown;
    next_cur.ctl.chan_clk_en = ~next_cur.shutdown;
    next_cur.ctl.quant_preset = next_cur.soft_reset;
    next_cur.ctl.filter_clear = next_cur.soft_reset & ~next_cur.shutdown;
    next_cur.ctl.core_clk_en = (next_cur.shutdown != ALL_DOWN);
    next_cur.ctl.input_clk_en = (next_cur.shutdown != ALL_DOWN);
    next_cur.ctl.vref_en = ~((next_cur.shutdown == ALL_DOWN)
      & next_cur.ext_ref & next_cur.ext_clk);
    // supply monitors drop only with the reference, in full power-down
    next_cur.ctl.monitor_en = next_cur.ctl.vref_en;
    next_cur.ctl.serial_reset = 1'h0;

    if (hard)
    begin
      // everything back to defaults except the synchronisers themselves
      next_cur = reset_state();
      next_cur.pin_sync = {cur.pin_sync[1:0], reset_pin_n};
      next_cur.por_sync = {cur.por_sync[1:0], por_detect};
      next_cur.pin_level = cur.pin_level;
      next_cur.por_level = cur.por_level;
      if (cur.pin_sync[1] == cur.pin_sync[2])
      begin
        next_cur.pin_level = cur.pin_sync[2];
      end
      if (cur.por_sync[1] == cur.por_sync[2])
      begin
        next_cur.por_level = cur.por_sync[2];
      end
      // biases stay up: the part is ready to convert once released
      next_cur.ctl.bias_en = ~SHUTDOWN_RESET;
      next_cur.ctl.chan_clk_en = ~SHUTDOWN_RESET;
      next_cur.ctl.core_clk_en = 1'h1;
      next_cur.ctl.input_clk_en = 1'h1;
      next_cur.ctl.vref_en = 1'h1;
      next_cur.ctl.monitor_en = 1'h1;
      next_cur.ctl.quant_preset = ALL_DOWN;
      next_cur.ctl.filter_clear = ALL_DOWN;
      // bus readies held low so no traffic is taken
      next_cur.ctl.serial_reset = 1'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    // pin-driven hard reset lives in the next-state logic, not here
    if (!aresetn)
    begin
      cur <= reset_state();
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign axi_rsp = cur.rsp;
  assign data_out = cur.dout;
  assign data_ready = cur.drdy;
  assign power_ctl = cur.ctl;

endmodule

// ---- tb/afe_host_model.sv ----
// Purpose: host side of the reset pin
// Assumes: bench keeps aclk running throughout
// Notes: bus_hold tells the bench to keep the bus quiet
`timescale 1ns/1ps
module afe_host_model (
  input wire logic aclk,
  input wire logic want_reset,
  input wire logic por_detect,
  output logic reset_pin_n,
  output logic bus_hold
);
  logic [3:0] guard;
  initial reset_pin_n = 1'b1;
  initial guard = 4'h0;
  // clock never paused while the pin is low
  always @(posedge aclk)
  begin
    reset_pin_n <= !want_reset;
    guard <= (want_reset || por_detect) ? 4'hF : guard - 4'(guard != 4'h0);
  end
  // margin over the sync delay before the host talks again
  assign bus_hold = !reset_pin_n || por_detect || guard != 4'h0;
endmodule

// ---- tb/afe_power_asserts.sv ----
// Purpose: port-level checks for the reset and power block
// Assumes: one aclk domain, aresetn synchronous
// Notes: bound from the bench top file
`timescale 1ns/1ps
module afe_power_asserts
  import afe_power_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic por_detect,
  input wire axi_req_t axi_req,
  input wire axi_rsp_t axi_rsp,
  input wire logic [NUM_CH-1:0] conv_strobe,
  input wire logic [NUM_CH-1:0] data_ready,
  input wire power_ctl_t power_ctl
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // six cycles covers the three-stage pin sync
  sequence pin_held;
    (!reset_pin_n)[*6];
  endsequence
  sequence pins_idle;
    (reset_pin_n && !por_detect)[*6];
  endsequence
  hard_entry_a: assert property (pin_held |-> power_ctl.serial_reset)
    else $error("pin low without hard reset");
  hard_exit_a: assert property (pins_idle |=> !power_ctl.serial_reset)
    else $error("hard reset without cause");
  bus_quiet_a: assert property (power_ctl.serial_reset |->
    !axi_rsp.awready && !axi_rsp.wready && !axi_rsp.arready)
    else $error("bus ready during hard reset");
  hard_preset_a: assert property (power_ctl.serial_reset |->
    power_ctl.quant_preset == ALL_DOWN && power_ctl.filter_clear == ALL_DOWN)
    else $error("preset missing in hard reset");
  ready_cause_a: assert property ((data_ready & ~$past(conv_strobe)) == '0)
    else $error("data ready without strobe");
  down_quiet_a: assert property ((data_ready & ~power_ctl.chan_clk_en) == '0)
    else $error("data ready from stopped channel");
  clk_gate_a: assert property (power_ctl.core_clk_en == (|power_ctl.chan_clk_en)
    && power_ctl.input_clk_en == power_ctl.core_clk_en)
    else $error("core clock gating wrong");
  monitor_tie_a: assert property (power_ctl.monitor_en == power_ctl.vref_en)
    else $error("monitor enable differs");
  resp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=>
    axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
endmodule

// ---- tb/afe_reset_and_power_modes_tb.sv ----
// Purpose: self-checking bench for the reset and power block
// Assumes: 10 MHz aclk, AXI4-Lite master tasks
// Notes: settling wait uses the full package count
`timescale 1ns/1ps
module afe_reset_and_power_modes_tb;
  import afe_power_pkg::*;
  logic aclk, aresetn, por_detect, want_reset, reset_pin_n, bus_hold;
  axi_req_t req;
  axi_rsp_t rsp;
  logic [NUM_CH-1:0][DATA_W-1:0] conv_data, data_out;
  logic [NUM_CH-1:0] conv_strobe, data_ready;
  power_ctl_t ctl;
  logic [5:0] m;
  logic [31:0] d, v;
  logic [1:0] r;
  int seed = 33805;
  int err_total = 0;
  int checked = 0;
  initial aclk = 1'b0;
  always #50 aclk = ~aclk;
  afe_host_model i_host (.aclk(aclk), .want_reset(want_reset), .por_detect(por_detect),
    .reset_pin_n(reset_pin_n), .bus_hold(bus_hold));
  afe_reset_and_power_modes i_dut (.aclk(aclk), .aresetn(aresetn), .reset_pin_n(reset_pin_n),
    .por_detect(por_detect), .axi_req(req), .axi_rsp(rsp), .conv_data(conv_data),
    .conv_strobe(conv_strobe), .data_out(data_out), .data_ready(data_ready), .power_ctl(ctl));
  task report_and_stop;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("unexpected %0t %s", $time, msg);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] wd);
    int n;
    logic late;
    n = 0;
    late = 1'($random(seed));
    // a late bready leaves the response standing for a few cycles
    req <= '{1'b1, a, 1'b1, wd, 4'hF, !late, 1'b0, 8'h00, 1'b0};
    do
    begin
      @(posedge aclk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (n == 3) req.bready <= 1'b1;
    end
    while (!(rsp.bvalid === 1'b1 && req.bready === 1'b1) && n < 100);
    req.bready <= 1'b0;
    chk(n < 100 && rsp.bresp === RESP_OKAY, "write response");
    // one edge between transfers so no field is driven twice in one step
    @(posedge aclk);
  endtask
  task rdx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1 && n < 100);
    req.rready <= 1'b0;
    d = rsp.rdata;
    r = rsp.rresp;
    chk(n < 100 && r === er && (er !== RESP_OKAY || d === e), "read value");
    @(posedge aclk);
  endtask
  // strobe every channel once, then look at the registered outputs
  task pulse(input logic [5:0] exp_rdy, input string msg);
    logic [23:0] x;
    x = 24'($random(seed));
    @(posedge aclk);
    conv_data <= {6{x}};
    conv_strobe <= 6'h3F;
    @(posedge aclk);
    conv_strobe <= 6'h00;
    // outputs registered at the strobe edge are read before the next update
    @(posedge aclk);
    chk(data_ready === exp_rdy, msg);
    for (int i = 0; i < NUM_CH; i++) chk(data_out[i] === (exp_rdy[i] ? x : 24'h0), msg);
  endtask
  initial
  begin
    #(20000 * 100);
    err_total++;
    report_and_stop;
  end
  initial
  begin
    aresetn = 1'b0;
    por_detect = 1'b0;
    want_reset = 1'b0;
    req = '0;
    conv_strobe = '0;
    conv_data = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdx(SETUP_OFFSET, 32'h0, RESP_OKAY);
    rdx(8'h40, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? ALL_DOWN : 6'($random(seed));
      wr(SETUP_OFFSET, {26'h0, m});
      rdx(SETUP_OFFSET, {26'h0, m}, RESP_OKAY);
      chk(ctl.bias_en === ~m && ctl.chan_clk_en === ~m, "bias");
      chk(ctl.core_clk_en === (m != ALL_DOWN), "core clock");
    end
    wr(SETUP_OFFSET, 32'h0);
    repeat (SETTLE_CYCLES + 5) @(posedge aclk);
    wr(SETUP_OFFSET, 32'h05);
    pulse(6'h3A, "down channel");
    wr(SETUP_OFFSET, 32'h0);
    pulse(6'h3A, "settling");
    repeat (SETTLE_CYCLES) @(posedge aclk);
    pulse(6'h3F, "resumed");
    wr(SETUP_OFFSET, 32'h1 << (SOFT_RESET_LSB + 1));
    pulse(6'h3D, "soft reset");
    chk(ctl.quant_preset === 6'h02 && ctl.bias_en === 6'h3F, "soft preset");
    v = 32'h3F | (32'h1 << EXT_REF_BIT) | (32'h1 << EXT_CLK_BIT);
    wr(SETUP_OFFSET, v);
    rdx(SETUP_OFFSET, v, RESP_OKAY);
    rdx(STATUS_OFFSET, (32'h3F << ST_SETTLING_LSB) | (32'h1 << ST_FULL_DOWN_BIT),
      RESP_OKAY);
    chk(d[ST_FULL_DOWN_BIT] === 1'b1 && ctl.vref_en === 1'b0, "full down");
    wr(SETUP_OFFSET, v & ~(32'h1 << EXT_CLK_BIT));
    repeat (2) @(posedge aclk);
    chk(ctl.monitor_en === 1'b1, "monitor back");
    for (int k = 0; k < 2; k++)
    begin
      wr(SETUP_OFFSET, 32'h3);
      want_reset <= (k == 0);
      por_detect <= (k == 1);
      repeat (8) @(posedge aclk);
      chk(ctl.serial_reset === 1'b1 && rsp.arready === 1'b0, "hard reset");
      chk(ctl.quant_preset === ALL_DOWN && ctl.filter_clear === ALL_DOWN, "preset");
      want_reset <= 1'b0;
      por_detect <= 1'b0;
      @(posedge aclk);
      wait (bus_hold === 1'b0);
      @(posedge aclk);
      rdx(SETUP_OFFSET, 32'h0, RESP_OKAY);
    end
    report_and_stop;
  end
endmodule
bind afe_reset_and_power_modes afe_power_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
  .reset_pin_n(reset_pin_n), .por_detect(por_detect), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .conv_strobe(conv_strobe), .data_ready(data_ready), .power_ctl(power_ctl));
